/* t8wo_map.vh */
// Constants for the 8-bit timer waveform output control block.
// Assumes inclusion by bare name from the design files.
`ifndef T8WO_MAP_VH
`define T8WO_MAP_VH

// Register offsets
`define T8WO_CTRL_A_OFS 8'h30
`define T8WO_COUNT_OFS 8'h3d
`define T8WO_STATUS_OFS 8'h3e

// Control register A fields
`define T8WO_OUT_A_HI 7
`define T8WO_OUT_A_LO 6
`define T8WO_OUT_B_HI 5
`define T8WO_OUT_B_LO 4
`define T8WO_MODE_HI 1
`define T8WO_MODE_LO 0
`define T8WO_CTRL_WMASK 8'hf3
`define T8WO_CTRL_RESET 8'h00

// Waveform modes
`define T8WO_MODE_NORMAL 3'h0
`define T8WO_MODE_PC_FF 3'h1
`define T8WO_MODE_CTC 3'h2
`define T8WO_MODE_FAST_FF 3'h3
`define T8WO_MODE_RSV4 3'h4
`define T8WO_MODE_PC_CA 3'h5
`define T8WO_MODE_RSV6 3'h6
`define T8WO_MODE_FAST_CA 3'h7

// Output action codes
`define T8WO_ACT_OFF 2'h0
`define T8WO_ACT_TOGGLE 2'h1
`define T8WO_ACT_CLEAR 2'h2
`define T8WO_ACT_SET 2'h3

// Counter limits
`define T8WO_MAX 8'hff
`define T8WO_BOTTOM 8'h00

`endif

/* t8wo_channel.v */
// One compare output channel: waveform flip-flop and pin takeover.
// Assumes event inputs are one-cycle pulses on timer ticks.
`timescale 1ns/1ps
`include "t8wo_map.vh"

module t8wo_channel (
    input wire clock,
    input wire resetn,
    input wire pwm_fast,
    input wire pwm_phase,
    input wire [1:0] action_field,
    input wire toggle_ok,
    input wire match,
    input wire at_bottom,
    input wire at_top,
    input wire counting_up,
    input wire cmp_is_top,
    output reg wave_out,
    output wire connected
);
    wire pwm = pwm_fast | pwm_phase;
    reg wave_next;

    // Code 01 in PWM modes only connects when toggling is allowed
    assign connected = (action_field != `T8WO_ACT_OFF) &&
        !(pwm && action_field == `T8WO_ACT_TOGGLE && !toggle_ok); // RULE1 RULE4 RULE6

    always @* begin
        wave_next = wave_out;
        if (!pwm) begin
            if (match) begin
                case (action_field) // RULE3
                    `T8WO_ACT_TOGGLE: wave_next = ~wave_out;
                    `T8WO_ACT_CLEAR: wave_next = 1'b0;
                    `T8WO_ACT_SET: wave_next = 1'b1;
                    default: wave_next = wave_out;
                endcase
            end
        end else if (action_field == `T8WO_ACT_TOGGLE) begin
            if (match && toggle_ok)
                wave_next = ~wave_out; // RULE4
        end else if (action_field[1]) begin
            if (pwm_fast) begin
                // Match ignored when compare equals top
                if (match && !cmp_is_top)
                    wave_next = action_field[0]; // RULE5 RULE6 RULE8
                else if (at_bottom)
                    wave_next = ~action_field[0]; // RULE5 RULE6 RULE8
            end else begin
                if (cmp_is_top) begin
                    if (at_top)
                        wave_next = ~action_field[0]; // RULE9
                end else if (match) begin
                    wave_next = counting_up ? action_field[0] : ~action_field[0]; // RULE7
                end
            end
        end
    end

    always @(posedge clock) begin
        if (!resetn)
            wave_out <= 1'b0;
        else
            wave_out <= wave_next;
    end
endmodule

/* t8wo_top.v */
// Behaviour
// RULE1: A nonzero compare-output field makes the waveform output replace the port pin; PWM code 01 keeps the port pin except channel A with mode bit 2 set.
// RULE2: The pin is driven only while its direction bit selects output.
// RULE3: Non-PWM codes: off, toggle, clear, set on compare match.
// RULE4: In PWM, channel A code 01 toggles only when mode bit 2 is set.
// RULE5: Fast PWM channel A: 10 non-inverting, 11 inverting, edge at bottom.
// RULE6: Fast PWM channel B same as A; code 01 reserved in PWM.
// RULE7: Phase-correct: 10 clears on up match, sets on down match; 11 opposite.
// RULE8: Fast PWM with compare at top and upper bit: match ignored, bottom edge only.
// RULE9: Phase-correct with compare at top and upper bit: action taken at top.
// RULE10: Control bits 3 and 2 read zero and ignore writes.
// RULE11: Mode is two control bits plus a third bit from elsewhere.
// RULE12: Modes 0 and 2 count up, tops 0xFF and A, immediate update, overflow at MAX.
// RULE13: Fast modes 3 and 7: top 0xFF or A, update at bottom, overflow MAX/top.
// RULE14: Phase modes 1 and 5: top 0xFF or A, update at top, overflow at bottom.
// RULE15: Software never selects reserved modes 4 or 6.
// RULE16: MAX is 0xFF and BOTTOM is 0x00.
// RULE17: Control writes take effect on the next clock cycle.
//
// Mode and compare output control of an 8-bit timer/counter.
// Assumes timer_tick is a one-cycle enable from an outside prescaler.
`timescale 1ns/1ps
`include "t8wo_map.vh"

module t8wo_top (
    input wire clock,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire waveform_mode_bit2,
    input wire timer_tick,
    input wire [7:0] compare_value_a,
    input wire [7:0] compare_value_b,
    input wire ddr_a,
    input wire ddr_b,
    input wire port_a_data,
    input wire port_b_data,
    output wire pin_a_out,
    output wire pin_a_oe,
    output wire pin_b_out,
    output wire pin_b_oe,
    output wire wave_out_a,
    output wire wave_out_b,
    output reg [7:0] count_value,
    output reg overflow_flag,
    output reg match_a,
    output reg match_b
);
    reg [7:0] ctrl_reg;
    reg [7:0] ctrl_next;
    reg up_reg;
    reg up_next;
    reg [7:0] cmp_a_reg;
    reg [7:0] cmp_b_reg;
    reg [7:0] count_next;
    reg [7:0] top_val;
    reg upd_now;
    reg ovf_now;

    wire [2:0] waveform_mode_field;
    wire [1:0] out_a_action_field;
    wire [1:0] out_b_action_field;
    wire pwm_fast;
    wire pwm_phase;
    wire top_from_a;
    wire at_top;
    wire at_bottom_evt;
    wire [1:0] wave_vec;
    wire [1:0] conn_vec;
    wire [1:0] ddr_vec;
    wire [1:0] port_vec;
    wire [1:0] match_vec;
    wire [1:0] cmp_top_vec;
    wire [3:0] field_vec;

    // Fast PWM decode
    function is_fast;
        input [2:0] m;
        begin
            is_fast = (m == `T8WO_MODE_FAST_FF) || (m == `T8WO_MODE_FAST_CA);
        end
    endfunction

    // Phase-correct PWM decode
    function is_phase;
        input [2:0] m;
        begin
            is_phase = (m == `T8WO_MODE_PC_FF) || (m == `T8WO_MODE_PC_CA);
        end
    endfunction

    assign out_a_action_field = ctrl_reg[`T8WO_OUT_A_HI:`T8WO_OUT_A_LO];
    assign out_b_action_field = ctrl_reg[`T8WO_OUT_B_HI:`T8WO_OUT_B_LO];
    assign waveform_mode_field = {waveform_mode_bit2,
        ctrl_reg[`T8WO_MODE_HI:`T8WO_MODE_LO]}; // RULE11
    // Reserved modes fall back to plain counting
    assign pwm_fast = is_fast(waveform_mode_field); // RULE15
    assign pwm_phase = is_phase(waveform_mode_field); // RULE15
    assign top_from_a = (waveform_mode_field == `T8WO_MODE_CTC) ||
        (waveform_mode_field == `T8WO_MODE_PC_CA) ||
        (waveform_mode_field == `T8WO_MODE_FAST_CA);

    always @* begin
        top_val = top_from_a ? cmp_a_reg : `T8WO_MAX; // RULE12 RULE13 RULE14 RULE16
    end

    assign at_top = timer_tick && (count_value == top_val);
    // Fast PWM wraps to bottom on the tick at top
    assign at_bottom_evt = at_top && pwm_fast; // RULE5 RULE16

    // Control register write, bits 3:2 never stored
    always @* begin
        ctrl_next = ctrl_reg;
        if (reg_wr && reg_addr == `T8WO_CTRL_A_OFS)
            ctrl_next = reg_wdata & `T8WO_CTRL_WMASK; // RULE10
    end

    always @(posedge clock) begin
        if (!resetn)
            ctrl_reg <= `T8WO_CTRL_RESET;
        else
            ctrl_reg <= ctrl_next; // RULE17
    end

    // Read port, data one cycle after strobe
    always @(posedge clock) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `T8WO_CTRL_A_OFS: reg_rdata <= ctrl_reg & `T8WO_CTRL_WMASK; // RULE10
                `T8WO_COUNT_OFS: reg_rdata <= count_value;
                `T8WO_STATUS_OFS: reg_rdata <= {4'h0, up_reg, conn_vec[0] | conn_vec[1], wave_vec};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Counter sequence and direction
    always @* begin
        count_next = count_value;
        up_next = up_reg;
        if (timer_tick) begin
            if (pwm_phase) begin
                if (up_reg) begin
                    if (count_value == top_val) begin
                        up_next = 1'b0; // RULE14
                        count_next = count_value - 8'h01;
                    end else begin
                        count_next = count_value + 8'h01;
                    end
                end else begin
                    if (count_value == `T8WO_BOTTOM) begin
                        up_next = 1'b1; // RULE14 RULE16
                        count_next = count_value + 8'h01;
                    end else begin
                        count_next = count_value - 8'h01;
                    end
                end
            end else begin
                up_next = 1'b1;
                if (count_value == top_val)
                    count_next = `T8WO_BOTTOM; // RULE12 RULE13
                else
                    count_next = count_value + 8'h01;
            end
        end
    end

    // Compare buffer update point and overflow point per mode
    always @* begin
        upd_now = 1'b0;
        ovf_now = 1'b0;
        case (waveform_mode_field)
            `T8WO_MODE_FAST_FF: begin
                upd_now = at_top; // RULE13
                ovf_now = timer_tick && count_value == `T8WO_MAX; // RULE13
            end
            `T8WO_MODE_FAST_CA: begin
                upd_now = at_top; // RULE13
                ovf_now = at_top; // RULE13
            end
            `T8WO_MODE_PC_FF, `T8WO_MODE_PC_CA: begin
                upd_now = at_top && up_reg; // RULE14
                ovf_now = timer_tick && !up_reg && count_value == `T8WO_BOTTOM; // RULE14
            end
            default: begin
                upd_now = 1'b1; // RULE12
                ovf_now = timer_tick && count_value == `T8WO_MAX; // RULE12
            end
        endcase
    end

    always @(posedge clock) begin
        if (!resetn) begin
            count_value <= `T8WO_BOTTOM;
            up_reg <= 1'b1;
            cmp_a_reg <= 8'h00;
            cmp_b_reg <= 8'h00;
            overflow_flag <= 1'b0;
            match_a <= 1'b0;
            match_b <= 1'b0;
        end else begin
            count_value <= count_next;
            up_reg <= up_next;
            if (upd_now) begin
                cmp_a_reg <= compare_value_a;
                cmp_b_reg <= compare_value_b;
            end
            overflow_flag <= ovf_now;
            match_a <= match_vec[0];
            match_b <= match_vec[1];
        end
    end

    assign field_vec = {out_b_action_field, out_a_action_field};
    assign ddr_vec = {ddr_b, ddr_a};
    assign port_vec = {port_b_data, port_a_data};
    assign match_vec[0] = timer_tick && (count_value == cmp_a_reg);
    assign match_vec[1] = timer_tick && (count_value == cmp_b_reg);
    assign cmp_top_vec[0] = (cmp_a_reg == top_val);
    assign cmp_top_vec[1] = (cmp_b_reg == top_val);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            t8wo_channel u_chan (
                .clock(clock),
                .resetn(resetn),
                .pwm_fast(pwm_fast),
                .pwm_phase(pwm_phase),
                .action_field(field_vec[2 * ch + 1 -: 2]),
                .toggle_ok((ch == 0) ? waveform_mode_bit2 : 1'b0),
                .match(match_vec[ch]),
                .at_bottom(at_bottom_evt),
                .at_top(at_top && pwm_phase),
                .counting_up(up_reg),
                .cmp_is_top(cmp_top_vec[ch]),
                .wave_out(wave_vec[ch]),
                .connected(conn_vec[ch])
            );
        end
    endgenerate

    assign wave_out_a = wave_vec[0];
    assign wave_out_b = wave_vec[1];
    // Pin takes the waveform when connected, driver follows direction bit
    assign pin_a_out = conn_vec[0] ? wave_vec[0] : port_vec[0]; // RULE1
    assign pin_b_out = conn_vec[1] ? wave_vec[1] : port_vec[1]; // RULE1
    assign pin_a_oe = ddr_vec[0]; // RULE2
    assign pin_b_oe = ddr_vec[1]; // RULE2
endmodule

/* t8wo_monitor.sv */
// Concurrent checks on the waveform output control ports.
// Assumes binding to t8wo_top and a shadow of control writes.
`timescale 1ns/1ps
module t8wo_monitor (
    input wire clock,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire waveform_mode_bit2,
    input wire timer_tick,
    input wire [7:0] compare_value_a,
    input wire ddr_a,
    input wire ddr_b,
    input wire port_a_data,
    input wire port_b_data,
    input wire pin_a_out,
    input wire pin_a_oe,
    input wire pin_b_out,
    input wire pin_b_oe,
    input wire wave_out_a,
    input wire wave_out_b,
    input wire [7:0] count_value,
    input wire overflow_flag
);
    reg [7:0] sh_reg;
    reg [7:0] cq_reg;
    reg wrap_reg;
    wire [2:0] mode = {waveform_mode_bit2, sh_reg[1:0]};
    wire [1:0] fa = sh_reg[7:6];
    wire [1:0] fb = sh_reg[5:4];
    wire conn_a = (fa != 2'h0) && !(mode[0] && fa == 2'h1 && !mode[2]);
    wire conn_b = (fb != 2'h0) && !(mode[0] && fb == 2'h1);
    always @(posedge clock) begin
        cq_reg <= compare_value_a;
        if (!resetn) begin
            sh_reg <= 8'h00;
            wrap_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == 8'h30)
                sh_reg <= reg_wdata & 8'hf3;
            if (compare_value_a != cq_reg)
                wrap_reg <= 1'b0;
            else if (timer_tick && count_value == 8'hff)
                wrap_reg <= 1'b1;
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!resetn);
    pin_drive_a: assert property (pin_a_oe == ddr_a && pin_b_oe == ddr_b)
        else $error("pin enable differs from direction bit");
    pin_mux_a_a: assert property (pin_a_out == (conn_a ? wave_out_a : port_a_data))
        else $error("pin a source wrong");
    pin_mux_b_a: assert property (pin_b_out == (conn_b ? wave_out_b : port_b_data))
        else $error("pin b source wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    rdata_ctrl_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h30 |-> reg_rdata == $past(sh_reg))
        else $error("control read value wrong");
    ovf_normal_a: assert property (mode == 3'h0 && $stable(mode) && timer_tick && count_value == 8'hff
        |=> overflow_flag && count_value == 8'h00)
        else $error("normal mode wrap wrong");
    match_act_a: assert property (!mode[0] && $stable(mode) && fa != 2'h0 && timer_tick
        && count_value == compare_value_a && $stable(compare_value_a)
        |=> wave_out_a == ($past(fa) == 2'h1 ? !$past(wave_out_a) : $past(sh_reg[6])))
        else $error("non-pwm match action wrong");
    fast_bottom_a: assert property (mode == 3'h3 && $stable(mode) && sh_reg[7] && timer_tick && count_value == 8'hff
        |=> count_value == 8'h00 && wave_out_a == !$past(sh_reg[6]))
        else $error("fast pwm bottom action wrong");
    fast_match_a: assert property (mode == 3'h3 && sh_reg[7] && wrap_reg && timer_tick && $stable(compare_value_a)
        && count_value == compare_value_a && count_value != 8'hff |=> wave_out_a == $past(sh_reg[6]))
        else $error("fast pwm match action wrong");
    cover property (mode == 3'h3 && overflow_flag);
    cover property (mode == 3'h1 && overflow_flag);
    cover property (waveform_mode_bit2 && overflow_flag);
endmodule
bind t8wo_top t8wo_monitor mon (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .waveform_mode_bit2(waveform_mode_bit2),
    .timer_tick(timer_tick), .compare_value_a(compare_value_a), .ddr_a(ddr_a), .ddr_b(ddr_b),
    .port_a_data(port_a_data), .port_b_data(port_b_data), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .count_value(count_value),
    .overflow_flag(overflow_flag)
);

/* t8wo_top_tb.sv */
// Self-checking bench for the waveform output control block.
// Assumes a tick every cycle and counts pin highs over whole periods.
`timescale 1ns/1ps
module t8wo_top_tb;
    reg clock = 1'b0;
    reg resetn = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg waveform_mode_bit2 = 1'b0;
    reg timer_tick = 1'b0;
    reg [7:0] compare_value_a = 8'h00;
    reg [7:0] compare_value_b = 8'h00;
    reg ddr_a = 1'b1;
    reg ddr_b = 1'b1;
    reg port_a_data = 1'b0;
    reg port_b_data = 1'b0;
    wire [7:0] reg_rdata, count_value;
    wire pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, wave_out_a, wave_out_b, overflow_flag, match_a, match_b;
    integer fail_count = 0;
    integer num_checks = 0;
    always #25 clock = ~clock;
    t8wo_top uut (
        .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .waveform_mode_bit2(waveform_mode_bit2),
        .timer_tick(timer_tick), .compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
        .ddr_a(ddr_a), .ddr_b(ddr_b), .port_a_data(port_a_data), .port_b_data(port_b_data),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
        .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .count_value(count_value),
        .overflow_flag(overflow_flag), .match_a(match_a), .match_b(match_b)
    );
    task check(input string nm, input [9:0] exp, input [9:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value %s expected %0d seen %0d", nm, exp, got);
            end
        end
    endtask
    task print_verdict;
        begin
            $display("mismatches %0d checks %0d", fail_count, num_checks);
            if (fail_count == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clock);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clock);
            reg_rd <= 1'b0;
            #1;
            check("read data", {2'b00, e}, {2'b00, reg_rdata});
        end
    endtask
    // Sets mode and compares, settles, then counts highs and match pulses over n cycles
    task run(input [7:0] c, input b2, input [7:0] ca, input [7:0] cb,
        input [9:0] n, input [9:0] ea, input [9:0] eb, input [9:0] eo, input [9:0] ma, input [9:0] mb);
        integer i;
        integer ha;
        integer hb;
        integer ho;
        integer qa;
        integer qb;
        begin
            wr(8'h30, c);
            waveform_mode_bit2 <= b2;
            compare_value_a <= ca;
            compare_value_b <= cb;
            repeat (1100) @(posedge clock);
            ha = 0;
            hb = 0;
            ho = 0;
            qa = 0;
            qb = 0;
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clock);
                #1;
                ha = ha + (pin_a_out === 1'b1);
                hb = hb + (pin_b_out === 1'b1);
                ho = ho + (overflow_flag === 1'b1);
                qa = qa + (match_a === 1'b1);
                qb = qb + (match_b === 1'b1);
            end
            check("pin a highs", ea, ha[9:0]);
            check("pin b highs", eb, hb[9:0]);
            check("overflows", eo, ho[9:0]);
            check("matches a", ma, qa[9:0]);
            check("matches b", mb, qb[9:0]);
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        timer_tick <= 1'b1;
        rd(8'h3d, 8'h01);
        rd(8'h3e, 8'h08);
        rd(8'h30, 8'h00);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'hf3);
        wr(8'h31, 8'h00);
        rd(8'h30, 8'hf3);
        rd(8'h31, 8'h00);
        run(8'hb0, 1'b0, 8'h40, 8'h80, 10'd256, 10'd0, 10'd256, 10'd1, 10'd1, 10'd1);
        run(8'h72, 1'b0, 8'h3f, 8'h10, 10'd256, 10'd128, 10'd256, 10'd0, 10'd4, 10'd4);
        run(8'hd2, 1'b0, 8'h3f, 8'h10, 10'd256, 10'd256, 10'd128, 10'd0, 10'd4, 10'd4);
        run(8'hb3, 1'b0, 8'h40, 8'h80, 10'd256, 10'd65, 10'd127, 10'd1, 10'd1, 10'd1);
        run(8'hb3, 1'b0, 8'hff, 8'hff, 10'd256, 10'd256, 10'd0, 10'd1, 10'd1, 10'd1);
        run(8'h63, 1'b1, 8'h7f, 8'h20, 10'd256, 10'd128, 10'd66, 10'd2, 10'd2, 10'd2);
        run(8'hb1, 1'b0, 8'h40, 8'h80, 10'd510, 10'd128, 10'd254, 10'd1, 10'd2, 10'd2);
        run(8'hb1, 1'b0, 8'hff, 8'hff, 10'd510, 10'd510, 10'd0, 10'd1, 10'd1, 10'd1);
        run(8'hb1, 1'b1, 8'h7f, 8'h20, 10'd508, 10'd508, 10'd380, 10'd2, 10'd2, 10'd4);
        @(posedge clock);
        waveform_mode_bit2 <= 1'b0;
        port_a_data <= 1'b0;
        port_b_data <= 1'b0;
        ddr_a <= 1'b0;
        wr(8'h30, 8'h53);
        repeat (3) @(posedge clock);
        #1;
        check("pin a", 10'd0, {9'd0, pin_a_out});
        check("pin b", 10'd0, {9'd0, pin_b_out});
        @(posedge clock);
        port_a_data <= 1'b1;
        port_b_data <= 1'b1;
        @(posedge clock);
        #1;
        check("pin a", 10'd1, {9'd0, pin_a_out});
        check("pin b", 10'd1, {9'd0, pin_b_out});
        check("pin a enable", 10'd0, {9'd0, pin_a_oe});
        check("pin b enable", 10'd1, {9'd0, pin_b_oe});
        print_verdict;
    end
    initial begin
        repeat (40000) @(posedge clock);
        fail_count = fail_count + 1;
        print_verdict;
    end
endmodule
